// ==== include/itt_defs.svh ====
// Offsets, field positions, reset values and counts of the idle interval timer
`ifndef ITT_DEFS_SVH
`define ITT_DEFS_SVH

`define ITT_ADDR_W 12
`define ITT_ADDR_MODE 12'h000
`define ITT_ADDR_ICTL 12'h004
`define ITT_ADDR_STAT 12'h008
`define ITT_ADDR_MASK 12'h00c

`define ITT_MODE_RST 8'h40
`define ITT_RESERVED_BIT_BIT 3
`define ITT_CSEL_BIT 4
`define ITT_DUAL_CLK_ENABLE_BIT 5
`define ITT_HIGH_OSC_ON_BIT 6
`define ITT_LOW_OSC_ON_BIT 7

`define ITT_EN_BIT 4
`define ITT_PND_BIT 5
`define ITT_GIE_BIT 0

`define ITT_EV_W 3
`define ITT_EV_INTERVAL 0
`define ITT_EV_START 1
`define ITT_EV_RSTREQ 2
`define ITT_EV_RST 3'h0
`define ITT_MASK_RST 3'h0

`define ITT_CNT_W 16
`define ITT_CNT_RST 16'h0000
`define ITT_TAP_BASE 11
`define ITT_TAP_N 5
`define ITT_SEL_MAX 3'h4
`define ITT_SEL_RST 3'h0
`define ITT_WDOG_TAP 4
`define ITT_START_TAP 0

`define ITT_DIV_W 4
`define ITT_DIV_LAST 4'h9

`endif

// ==== include/itt_pkg.sv ====
// Types of the idle interval timer
package itt_pkg;

  typedef enum logic {ITT_ST_IDLE, ITT_ST_WAIT} itt_start_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] mode;
    logic slow;
    logic pnd;
    logic en;
    logic global_irq_enable;
    logic [2:0] stat;
    logic [2:0] mask;
    itt_start_t st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic int_req;
    logic wake;
    logic wdog;
    logic start_done;
    logic rst_req;
  } itt_state_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } itt_div_state_t;

  typedef struct packed {
    logic samp;
    logic prev;
    logic tick;
  } itt_edge_state_t;

endpackage

// ==== logic/itt_hs_div.sv ====
// Divide-by-ten instruction-cycle tick, stopped while not running
`timescale 1ns/1ps
`default_nettype none
`include "itt_defs.svh"

module itt_hs_div (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  output logic o_tick
);

  itt_pkg::itt_div_state_t q;
  itt_pkg::itt_div_state_t d;

  always_comb begin
    d = q;
    d.tick = i_run && (q.cnt == `ITT_DIV_LAST);
    if (!i_run) begin
      // Held still, saves power in slow modes
      d.cnt = '0;
    end else if (q.cnt == `ITT_DIV_LAST) begin
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + 4'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

endmodule
`default_nettype wire

// ==== logic/itt_lf_edge.sv ====
// Rising-edge tick from the low-frequency clock input
`timescale 1ns/1ps
`default_nettype none

module itt_lf_edge (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic i_lf_clk,
  output logic o_tick
);

  itt_pkg::itt_edge_state_t q;
  itt_pkg::itt_edge_state_t d;

  always_comb begin
    d = q;
    d.samp = i_lf_clk;
    d.prev = q.samp;
    d.tick = i_run && q.samp && !q.prev;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

endmodule
`default_nettype wire

// ==== logic/itt_top.sv ====
// Idle interval timer with APB registers, interrupt logic and start-up delay
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "itt_defs.svh"

module itt_top (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [11:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_lf_clk,
  input wire logic i_startup_req,
  output logic o_irq,
  output logic o_interval_irq,
  output logic o_port_g6_clr,
  output logic o_wdog_tick,
  output logic o_startup_done,
  output logic o_reset_req,
  output logic o_slow_mode
);

  itt_pkg::itt_state_t q;
  itt_pkg::itt_state_t d;

  logic hs_tick;
  logic lf_tick;
  logic tick;
  logic [`ITT_TAP_N-1:0] uf_vec;
  logic interval_ev;
  logic [2:0] sel;
  logic setup_cyc;
  logic done_cyc;
  logic hit_mode;
  logic hit_ictl;
  logic hit_stat;
  logic hit_mask;
  logic wr_mode;
  logic wr_ictl;
  logic wr_mask;
  logic rd_stat_clr;
  logic rst_ev;
  logic start_ev;
  logic [`ITT_EV_W-1:0] ev;

  // Divider stops whenever the low clock is in use
  itt_hs_div u_hs_div (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_run(!q.slow),
    .o_tick(hs_tick)
  );

  itt_lf_edge u_lf_edge (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_run(q.slow),
    .i_lf_clk(i_lf_clk),
    .o_tick(lf_tick)
  );

  // Core clock is the doubled oscillator, so a tenth of it is one fifth of the oscillator
  assign tick = q.slow ? lf_tick : hs_tick;

  // A tap bit underflows when it and every bit below it are zero as a tick lands
  for (genvar g = 0; g < `ITT_TAP_N; g++) begin : g_tap
    assign uf_vec[g] = tick && (q.cnt[`ITT_TAP_BASE+g:0] == '0);
  end

  assign sel = q.mode[2:0];
  // Reserved codes produce no interval event; start-up and watchdog taps still fire
  assign interval_ev = (sel <= `ITT_SEL_MAX) ? uf_vec[sel] : 1'b0;

  assign setup_cyc = i_psel && i_penable && !q.pready;
  assign done_cyc = i_psel && i_penable && q.pready;
  assign hit_mode = (i_paddr == `ITT_ADDR_MODE);
  assign hit_ictl = (i_paddr == `ITT_ADDR_ICTL);
  assign hit_stat = (i_paddr == `ITT_ADDR_STAT);
  assign hit_mask = (i_paddr == `ITT_ADDR_MASK);
  assign wr_mode = done_cyc && i_pwrite && hit_mode;
  assign wr_ictl = done_cyc && i_pwrite && hit_ictl;
  assign wr_mask = done_cyc && i_pwrite && hit_mask;
  // Cleared as the snapshot is taken, so nothing arrives unseen in between
  assign rd_stat_clr = setup_cyc && !i_pwrite && hit_stat;
  assign rst_ev = wr_mode && (i_pwdata[7:4] == 4'h0);
  assign start_ev = (q.st == itt_pkg::ITT_ST_WAIT) && uf_vec[`ITT_START_TAP];
  assign ev = {rst_ev, start_ev, interval_ev};

  always_comb begin
    d = q;
    // Counter itself is never on the bus
    d.cnt = tick ? q.cnt - 16'h0001 : q.cnt;

    if (wr_mode) begin
      d.mode = i_pwdata[7:0];
      // Reserved bit kept at zero whatever is written
      d.mode[`ITT_RESERVED_BIT_BIT] = 1'b0;
    end
    d.slow = d.mode[`ITT_CSEL_BIT] || d.mode[`ITT_DUAL_CLK_ENABLE_BIT];

    if (wr_ictl) begin
      d.en = i_pwdata[`ITT_EN_BIT];
      d.global_irq_enable = i_pwdata[`ITT_GIE_BIT];
    end
    // Writing zero clears, writing one leaves it; a new event wins the tie
    d.pnd = interval_ev || (q.pnd && !(wr_ictl && !i_pwdata[`ITT_PND_BIT]));
    d.int_req = d.pnd && d.en && d.global_irq_enable;

    if (wr_mask) begin
      d.mask = i_pwdata[`ITT_EV_W-1:0];
    end
    d.stat = ev | (rd_stat_clr ? `ITT_EV_RST : q.stat);
    d.irq = |(d.stat & d.mask);

    d.wake = interval_ev;
    d.wdog = uf_vec[`ITT_WDOG_TAP];
    d.rst_req = rst_ev;
    d.start_done = start_ev;

    case (q.st)
      itt_pkg::ITT_ST_IDLE: begin
        if (i_startup_req) begin
          d.st = itt_pkg::ITT_ST_WAIT;
        end
      end
      itt_pkg::ITT_ST_WAIT: begin
        // Start-up delay after halt or brownout rides the same counter
        if (start_ev) begin
          d.st = itt_pkg::ITT_ST_IDLE;
        end
      end
      default: begin
        d.st = itt_pkg::ITT_ST_IDLE;
      end
    endcase

    // One wait state: answer always in the second access cycle
    d.pready = setup_cyc;
    d.pslverr = 1'b0;
    if (setup_cyc) begin
      d.pslverr = !(hit_mode || hit_ictl || hit_stat || hit_mask);
      d.prdata = 32'h0000_0000;
      if (!i_pwrite) begin
        case (1'b1)
          hit_mode: d.prdata = {24'h00_0000, q.mode};
          hit_ictl: d.prdata = {26'h000_0000, q.pnd, q.en, 3'h0, q.global_irq_enable};
          hit_stat: d.prdata = {29'h0000_0000, q.stat};
          hit_mask: d.prdata = {29'h0000_0000, q.mask};
          default: d.prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      q <= '0;
      q.cnt <= `ITT_CNT_RST;
      q.mode <= `ITT_MODE_RST;
      q.stat <= `ITT_EV_RST;
      q.mask <= `ITT_MASK_RST;
      q.st <= itt_pkg::ITT_ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign o_prdata = q.prdata;
  assign o_pready = q.pready;
  assign o_pslverr = q.pslverr;
  assign o_irq = q.irq;
  assign o_interval_irq = q.int_req;
  assign o_port_g6_clr = q.wake;
  assign o_wdog_tick = q.wdog;
  assign o_startup_done = q.start_done;
  assign o_reset_req = q.rst_req;
  assign o_slow_mode = q.slow;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_hs_run;
    hs_tick ##1 (!q.slow) [*8] ##1 !q.slow ##1 !q.slow;
  endsequence

  sequence s_mode_zero_write;
    wr_mode ##0 (i_pwdata[7:4] == 4'h0);
  endsequence

  a_cnt_decrement: assert property (tick |=> q.cnt == $past(q.cnt) - 16'h0001)
    else $error("interval counter did not step down on tick");

  a_cnt_hold: assert property (!tick |=> $stable(q.cnt))
    else $error("interval counter moved without tick");

  a_hs_period: assert property (s_hs_run |-> hs_tick)
    else $error("instruction tick not every ten core clocks");

  a_slow_source: assert property (q.slow |-> (tick == lf_tick))
    else $error("slow mode not clocked from low clock");

  a_div_stopped: assert property (q.slow && $past(q.slow) |-> !hs_tick)
    else $error("divider running in slow mode");

  a_pend_set: assert property (interval_ev |=> q.pnd && o_port_g6_clr)
    else $error("underflow did not set pending and wake");

  a_irq_gate: assert property (o_interval_irq == (q.pnd && q.en && q.global_irq_enable))
    else $error("interval interrupt not gated by both enables");

  a_reserved_sel: assert property (sel > `ITT_SEL_MAX |-> !interval_ev)
    else $error("reserved select produced an event");

  a_sel_reset: assert property (!$past(i_resetn) |-> sel == `ITT_SEL_RST)
    else $error("period select not cleared by reset");

  a_zero_write_rst: assert property (s_mode_zero_write |=> o_reset_req)
    else $error("zero write to clock bits gave no reset request");

  a_pend_sticky: assert property (q.pnd && !wr_ictl |=> q.pnd)
    else $error("pending flag dropped without a clearing write");

  a_apb_one_wait: assert property (setup_cyc |=> o_pready ##1 !o_pready)
    else $error("APB answer not exactly one cycle after wait");

  a_wdog_pulse: assert property (uf_vec[`ITT_WDOG_TAP] |=> o_wdog_tick)
    else $error("watchdog base tick missing after top bit underflow");

  a_start_end: assert property (start_ev |=> o_startup_done)
    else $error("start-up delay end not reported");

  a_wake_source: assert property (o_port_g6_clr |-> $past(interval_ev))
    else $error("idle exit pulse without interval event");

  a_stat_sticky: assert property (q.stat[0] && !rd_stat_clr |=> q.stat[0])
    else $error("interval status bit lost without a read");

  a_unmapped_err: assert property (setup_cyc && !(hit_mode || hit_ictl || hit_stat || hit_mask) |=> o_pslverr)
    else $error("unmapped access answered without error");

endmodule
`default_nettype wire

// ==== bench/idle_timer_interval_tb_top.sv ====
// Self-checking testbench of the idle interval timer
`timescale 1ns/1ps
`default_nettype none
`include "itt_defs.svh"

module idle_timer_interval_tb_top;
  localparam int FAST_DIV = 10;
  localparam int LF_PER = 4;
  localparam int TICKS0 = 4096;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic lf_clk = 1'b0;
  logic lf_ph = 1'b0;
  logic lf_run = 1'b0;
  logic startup_req = 1'b0;
  logic irq;
  logic interval_irq;
  logic g6_clr;
  logic wdog;
  logic st_done;
  logic rst_req;
  logic slow;
  logic [31:0] rd;
  logic err;
  logic seen;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int g6_n = 0;
  int g6_last = 0;
  int g6_prev = 0;
  int done_last = 0;
  int wd_n = 0;
  int k;

  itt_top i_itt_top (
    .i_core_clk(clk),
    .i_resetn(rstn),
    .i_paddr(paddr),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_lf_clk(lf_clk),
    .i_startup_req(startup_req),
    .o_irq(irq),
    .o_interval_irq(interval_irq),
    .o_port_g6_clr(g6_clr),
    .o_wdog_tick(wdog),
    .o_startup_done(st_done),
    .o_reset_req(rst_req),
    .o_slow_mode(slow)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Event times and a slow clock of LF_PER core cycles; timeout bounds the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (g6_clr === 1'b1) begin
      g6_n <= g6_n + 1;
      g6_prev <= g6_last;
      g6_last <= cyc;
    end
    if (wdog === 1'b1) begin
      wd_n <= wd_n + 1;
    end
    if (st_done === 1'b1) begin
      done_last <= cyc;
    end
    if (lf_run) begin
      lf_ph <= ~lf_ph;
      if (lf_ph) begin
        lf_clk <= ~lf_clk;
      end
    end
    if (cyc >= 100000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Setup one edge after entry so psel never changes twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 20), 32'h00000001, "apb answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd & m, exp, "read");
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  task automatic waitg6(input int n);
    repeat (45000) begin
      if (g6_n >= n) break;
      @(posedge clk);
    end
    chk(32'(g6_n >= n), 32'h00000001, "event wait");
  endtask

  task automatic t_fast();
    waitg6(1);
    chk(32'(wd_n), 32'h00000001, "watchdog base");
    rdchk(`ITT_ADDR_MODE, 32'hffffffff, 32'h00000040);
    rdchk(`ITT_ADDR_MASK, 32'hffffffff, 32'h00000000);
    rdchk(`ITT_ADDR_ICTL, 32'hffffffff, 32'h00000020);
    rdchk(`ITT_ADDR_STAT, 32'hffffffff, 32'h00000001);
    rdchk(12'h010, 32'hffffffff, 32'h00000000);
    chk({31'h0, err}, 32'h00000001, "unmapped err");
    waitg6(2);
    chk(32'(g6_last - g6_prev), 32'(TICKS0 * FAST_DIV), "fast period");
    $display("test fast done");
  endtask

  task automatic t_irq();
    apb(1'b1, `ITT_ADDR_ICTL, 32'h00000031);
    settle();
    chk({31'h0, interval_irq}, 32'h00000001, "irq all set");
    apb(1'b1, `ITT_ADDR_ICTL, 32'h00000021);
    settle();
    chk({31'h0, interval_irq}, 32'h00000000, "irq en off");
    apb(1'b1, `ITT_ADDR_ICTL, 32'h00000030);
    settle();
    chk({31'h0, interval_irq}, 32'h00000000, "irq gie off");
    apb(1'b1, `ITT_ADDR_ICTL, 32'h00000011);
    apb(1'b1, `ITT_ADDR_ICTL, 32'h00000031);
    rdchk(`ITT_ADDR_ICTL, 32'hffffffff, 32'h00000011);
    chk({31'h0, interval_irq}, 32'h00000000, "irq cleared");
    chk({31'h0, irq}, 32'h00000000, "masked irq");
    apb(1'b1, `ITT_ADDR_MASK, 32'h00000001);
    settle();
    chk({31'h0, irq}, 32'h00000001, "unmasked irq");
    rdchk(`ITT_ADDR_STAT, 32'h00000001, 32'h00000001);
    settle();
    chk({31'h0, irq}, 32'h00000000, "irq after read");
    $display("test irq done");
  endtask

  // Period change with the interrupt off, pending cleared before use
  task automatic t_period();
    apb(1'b1, `ITT_ADDR_ICTL, 32'h00000001);
    apb(1'b1, `ITT_ADDR_MODE, 32'h00000041);
    apb(1'b1, `ITT_ADDR_ICTL, 32'h00000001);
    rdchk(`ITT_ADDR_ICTL, 32'hffffffff, 32'h00000001);
    rdchk(`ITT_ADDR_MODE, 32'hffffffff, 32'h00000041);
    apb(1'b1, `ITT_ADDR_MODE, 32'h00000045);
    rdchk(`ITT_ADDR_MODE, 32'hffffffff, 32'h00000045);
    settle();
    chk({31'h0, interval_irq}, 32'h00000000, "irq stays off");
    $display("test period done");
  endtask

  task automatic t_mode();
    apb(1'b1, `ITT_ADDR_MODE, 32'h00000008);
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk);
      seen = seen | (rst_req === 1'b1);
    end
    chk({31'h0, seen}, 32'h00000001, "reset request");
    rdchk(`ITT_ADDR_MODE, 32'hffffffff, 32'h00000000);
    apb(1'b1, `ITT_ADDR_MODE, 32'h00000048);
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk);
      seen = seen | (rst_req === 1'b1);
    end
    chk({31'h0, seen}, 32'h00000000, "no reset request");
    rdchk(`ITT_ADDR_MODE, 32'hffffffff, 32'h00000040);
    rdchk(`ITT_ADDR_STAT, 32'h00000004, 32'h00000004);
    $display("test mode done");
  endtask

  // Slow clock: the divider must not add ticks, start-up ends on next bit 11 underflow
  task automatic t_slow();
    apb(1'b1, `ITT_ADDR_MODE, 32'h00000060);
    settle();
    chk({31'h0, slow}, 32'h00000001, "slow mode");
    lf_run <= 1'b1;
    k = g6_n;
    waitg6(k + 1);
    startup_req <= 1'b1;
    @(posedge clk);
    startup_req <= 1'b0;
    waitg6(k + 2);
    chk(32'(g6_last - g6_prev), 32'(TICKS0 * LF_PER), "slow period");
    settle();
    chk(32'(done_last > g6_prev + 2 && done_last < g6_last + 3), 32'h00000001, "startup");
    rdchk(`ITT_ADDR_STAT, 32'h00000002, 32'h00000002);
    chk(32'(wd_n), 32'h00000001, "no early watchdog");
    $display("test slow done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_fast();
    t_irq();
    t_period();
    t_mode();
    t_slow();
    end_sim();
  end
endmodule
`default_nettype wire
